// >>> src/rod_regs.svh
// Constants for the instruction decode front end: field positions, widths, encodings.
// Included by the package, the decoder and the testbench; holds definitions only.
`ifndef ROD_REGS_SVH
`define ROD_REGS_SVH
`define ROD_WORD_W 32
`define ROD_HALF_W 16
`define ROD_BYTE_W 8
`define ROD_DWORD_W 64
`define ROD_NUM_GPR 192
`define ROD_REG_W 8
`define ROD_OP_HI 31
`define ROD_OP_LO 24
`define ROD_DST_HI 23
`define ROD_DST_LO 16
`define ROD_SRCA_HI 15
`define ROD_SRCA_LO 8
`define ROD_SRCB_HI 7
`define ROD_SRCB_LO 0
`define ROD_IMM_BIT 24
`define ROD_OFF_HI 23
`define ROD_OFF_LO 8
`define ROD_CLS_HI 31
`define ROD_CLS_LO 28
`define ROD_SUB_HI 27
`define ROD_SUB_LO 25
`define ROD_MC_CNT_W 8
`define ROD_FP_CYCLES 8'h04
`define ROD_INTERRUPT_RETURN_OP_CYCLES 8'h02
`define ROD_BOOL_TRUE 32'h80000000
`define ROD_BOOL_FALSE 32'h00000000
`endif

// >>> src/rod_pkg.sv
// Types shared by the instruction decode front end.
// Assumes rod_regs.svh sits on the include path.
`include "rod_regs.svh"
package rod_pkg;
   typedef enum logic [3:0] {
      ROD_CLS_ARITH = 4'h0,
      ROD_CLS_CMP = 4'h1,
      ROD_CLS_LOGIC = 4'h2,
      ROD_CLS_SHIFT = 4'h3,
      ROD_CLS_MOVE = 4'h4,
      ROD_CLS_CONST = 4'h5,
      ROD_CLS_FP = 4'h6,
      ROD_CLS_BRANCH = 4'h7,
      ROD_CLS_MISC = 4'h8,
      ROD_CLS_ILLEGAL = 4'hF
   } rod_class_t;
   typedef enum logic [1:0] {
      ROD_ST_IDLE = 2'b00,
      ROD_ST_BUSY = 2'b01
   } rod_state_t;
   typedef struct packed {
      logic [7:0] dst;
      logic [7:0] src_a;
      logic [7:0] src_b;
      logic use_imm;
      logic [31:0] imm;
   } rod_operands_t;
   typedef struct packed {
      rod_class_t cls;
      logic [2:0] sub;
      logic multi_cycle;
      logic illegal;
      logic load_multiple_op;
      logic store_multiple_op;
      logic interrupt_return_op;
      logic assert_op;
      logic constant_high_op;
      logic signed_ext;
      logic [1:0] width;
   } rod_ctrl_t;
   typedef struct packed {
      logic is_branch;
      logic absolute;
      logic [31:0] target;
   } rod_branch_t;
endpackage

// >>> src/rod_decoder.sv
// Instruction decode front end: operand selects, immediates, branch targets,
// class and multi-cycle flags, assert traps, Boolean and byte-order helpers.
// Assumes one instruction per cycle when valid, and the pipeline honours busy.
// Overview of operation
// - Two sources and one destination each select any of 192 registers.
// - No register is reserved by hardware for any instruction class.
// - Most instructions may take an 8-bit constant instead of source B.
// - Relative branch: signed 16-bit word offset, scaled to bytes, added to PC.
// - Absolute branch: 16-bit word address turned into a byte address.
// - Floating point, interrupt return, load/store multiple are flagged multi-cycle.
// - Each instruction decodes into one of nine classes, or into the illegal class.
// - Assert compares raise a trap when the condition is false.
// - Shift class covers arithmetic, logical and double-word extract shifts.
// - Large constants are built by constant-class load and merge instructions.
// - Word 32, half 16, double 64, byte 8 bits; instructions are one word.
// - Signed or unsigned word, half, byte and FP types chosen by variant.
// - Boolean results live only in the word's top bit, 1 true.
// - Byte order 0: unit 0 sits at the most significant end.
// - Byte order 1: unit 0 sits at the least significant end.
// - The byte-order select is held in the configuration register.
// - Bit 0 is the least significant bit whatever the byte order.
`timescale 1ns/1ps
`include "rod_regs.svh"
module rod_decoder (
   input wire logic mclk_in, // 50 MHz clock
   input wire logic rst_b_in, // Async reset, active low
   input wire logic instr_valid_in, // Instruction word present
   input wire logic [31:0] instr_in, // Fetched instruction word
   input wire logic [31:0] pc_in, // Byte address of the instruction
   input wire logic cfg_we_in, // Configuration write strobe
   input wire logic byte_order_select_in, // Value written to the configuration bit
   input wire logic [31:0] cmp_a_in, // Comparison operand A
   input wire logic [31:0] cmp_b_in, // Comparison operand B
   input wire logic [31:0] ext_word_in, // Word for byte/half extraction
   input wire logic [1:0] ext_index_in, // Byte or half index
   output logic instr_accept_out, // Decoder takes the word this cycle
   output rod_pkg::rod_operands_t operands_out, // Registered operand selects
   output rod_pkg::rod_ctrl_t ctrl_out, // Registered class and flags
   output rod_pkg::rod_branch_t branch_out, // Registered branch target
   output logic decode_valid_out, // Registered outputs are fresh
   output logic trap_req_out, // Assert trap request pulse
   output logic illegal_out, // Illegal instruction pulse
   output logic busy_out, // Multi-cycle hold for the pipeline
   output logic [31:0] bool_out, // Comparison as a Boolean word
   output logic [31:0] ext_data_out, // Extracted byte or half-word
   output logic byte_order_select_out // Current byte-order setting
);
   rod_pkg::rod_state_t state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic bo_r, bo_nxt;
   rod_pkg::rod_operands_t ops_r, ops_nxt;
   rod_pkg::rod_ctrl_t ctl_r, ctl_nxt;
   rod_pkg::rod_branch_t br_r, br_nxt;
   logic dv_r, dv_nxt, trap_r, trap_nxt, ill_r, ill_nxt;
   logic [31:0] bool_r, bool_nxt, ext_r, ext_nxt;
   logic take;
   logic cmp_true;

   // Shared comparison for compare and assert subcodes
   function automatic logic cmp_eval(input logic [2:0] sub, input logic [31:0] a, input logic [31:0] b);
      case (sub)
         3'h0: cmp_eval = (a == b);
         3'h1: cmp_eval = (a != b);
         3'h2: cmp_eval = ($signed(a) < $signed(b));
         3'h3: cmp_eval = ($signed(a) <= $signed(b));
         3'h4: cmp_eval = ($signed(a) > $signed(b));
         3'h5: cmp_eval = ($signed(a) >= $signed(b));
         3'h6: cmp_eval = (a < b);
         default: cmp_eval = (a >= b);
      endcase
   endfunction

   assign take = instr_valid_in && (state_r == rod_pkg::ROD_ST_IDLE);
   assign instr_accept_out = take;
   assign cmp_true = cmp_eval(instr_in[`ROD_SUB_HI:`ROD_SUB_LO], cmp_a_in, cmp_b_in);

   always_comb begin
      logic [3:0] cls_f;
      logic [2:0] sub;
      logic [15:0] off;
      cls_f = instr_in[`ROD_CLS_HI:`ROD_CLS_LO];
      sub = instr_in[`ROD_SUB_HI:`ROD_SUB_LO];
      off = instr_in[`ROD_OFF_HI:`ROD_OFF_LO];
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      ops_nxt = ops_r;
      ctl_nxt = ctl_r;
      br_nxt = br_r;
      bool_nxt = bool_r;
      dv_nxt = 1'b0;
      trap_nxt = 1'b0;
      ill_nxt = 1'b0;
      bo_nxt = cfg_we_in ? byte_order_select_in : bo_r;
      if (state_r == rod_pkg::ROD_ST_BUSY) begin
         cnt_nxt = cnt_r - 8'h01;
         if (cnt_r == 8'h01) begin
            state_nxt = rod_pkg::ROD_ST_IDLE;
         end
      end
      if (take) begin
         dv_nxt = 1'b1;
         // Plain field slices: every class reaches every register
         ops_nxt.dst = instr_in[`ROD_DST_HI:`ROD_DST_LO];
         ops_nxt.src_a = instr_in[`ROD_SRCA_HI:`ROD_SRCA_LO];
         ops_nxt.src_b = instr_in[`ROD_SRCB_HI:`ROD_SRCB_LO];
         ops_nxt.use_imm = instr_in[`ROD_IMM_BIT];
         ops_nxt.imm = {24'h000000, instr_in[`ROD_SRCB_HI:`ROD_SRCB_LO]};
         ctl_nxt = '0;
         ctl_nxt.sub = sub;
         ctl_nxt.width = sub[1:0];
         ctl_nxt.signed_ext = sub[2];
         br_nxt = '0;
         case (cls_f)
            4'h0: ctl_nxt.cls = rod_pkg::ROD_CLS_ARITH;
            4'h1: ctl_nxt.cls = rod_pkg::ROD_CLS_CMP;
            4'h2: ctl_nxt.cls = rod_pkg::ROD_CLS_LOGIC;
            4'h3: ctl_nxt.cls = rod_pkg::ROD_CLS_SHIFT;
            4'h4: ctl_nxt.cls = rod_pkg::ROD_CLS_MOVE;
            4'h5: ctl_nxt.cls = rod_pkg::ROD_CLS_CONST;
            4'h6: ctl_nxt.cls = rod_pkg::ROD_CLS_FP;
            4'h7: ctl_nxt.cls = rod_pkg::ROD_CLS_BRANCH;
            4'h8: ctl_nxt.cls = rod_pkg::ROD_CLS_MISC;
            default: ctl_nxt.cls = rod_pkg::ROD_CLS_ILLEGAL;
         endcase
         // Shift subcodes 0..3: sll, srl, sra, extract, reserved above
         if (cls_f == 4'h3 && sub > 3'h3) begin
            ctl_nxt.cls = rod_pkg::ROD_CLS_ILLEGAL;
         end
         // Constant subcodes: low, high merge, high zero-lower, negative
         if (cls_f == 4'h5) begin
            ctl_nxt.constant_high_op = (sub == 3'h1) || (sub == 3'h2);
            ops_nxt.imm = (sub == 3'h3) ? {16'hFFFF, off} : {16'h0000, off};
            if (sub > 3'h3) begin
               ctl_nxt.cls = rod_pkg::ROD_CLS_ILLEGAL;
            end
         end
         if (cls_f == 4'h4) begin
            ctl_nxt.load_multiple_op = (sub == 3'h6);
            ctl_nxt.store_multiple_op = (sub == 3'h7);
         end
         if (cls_f == 4'h8) begin
            ctl_nxt.interrupt_return_op = (sub == 3'h0);
         end
         if (cls_f == 4'h7) begin
            br_nxt.is_branch = 1'b1;
            br_nxt.absolute = instr_in[`ROD_IMM_BIT];
            if (instr_in[`ROD_IMM_BIT]) begin
               br_nxt.target = {14'h0000, off, 2'b00};
            end else begin
               br_nxt.target = pc_in + {{14{off[15]}}, off, 2'b00};
            end
         end
         if (cls_f == 4'h1) begin
            ctl_nxt.assert_op = instr_in[`ROD_IMM_BIT];
            bool_nxt = cmp_true ? `ROD_BOOL_TRUE : `ROD_BOOL_FALSE;
            trap_nxt = instr_in[`ROD_IMM_BIT] && !cmp_true;
         end
         if (ctl_nxt.cls == rod_pkg::ROD_CLS_ILLEGAL) begin
            ctl_nxt.illegal = 1'b1;
            ill_nxt = 1'b1;
         end
         // Multi-cycle set; load/store multiple hold for src_b + 1 cycles from the internal count
         ctl_nxt.multi_cycle = (cls_f == 4'h6) || ctl_nxt.interrupt_return_op
                               || ctl_nxt.load_multiple_op || ctl_nxt.store_multiple_op;
         if (ctl_nxt.multi_cycle) begin
            state_nxt = rod_pkg::ROD_ST_BUSY;
            cnt_nxt = (cls_f == 4'h6) ? `ROD_FP_CYCLES : `ROD_INTERRUPT_RETURN_OP_CYCLES;
            if (ctl_nxt.load_multiple_op || ctl_nxt.store_multiple_op) begin
               cnt_nxt = ops_nxt.src_b + 8'h01;
            end
         end
      end
   end

   // Byte/half extraction; bit 0 stays the LSB in both orders
   always_comb begin
      logic [1:0] idx;
      idx = bo_r ? ext_index_in : ~ext_index_in;
      if (ctl_r.width == 2'b01) begin
         ext_nxt = idx[0] ? {16'h0000, ext_word_in[31:16]} : {16'h0000, ext_word_in[15:0]};
         if (ctl_r.signed_ext) begin
            ext_nxt[31:16] = {16{ext_nxt[15]}};
         end
      end else begin
         ext_nxt = {24'h000000, ext_word_in[8*idx +: 8]};
         if (ctl_r.signed_ext) begin
            ext_nxt[31:8] = {24{ext_nxt[7]}};
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r <= rod_pkg::ROD_ST_IDLE;
         cnt_r <= 8'h00;
         bo_r <= 1'b0;
         ops_r <= '0;
         ctl_r <= '0;
         br_r <= '0;
         dv_r <= 1'b0;
         trap_r <= 1'b0;
         ill_r <= 1'b0;
         bool_r <= 32'h00000000;
         ext_r <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         bo_r <= bo_nxt;
         ops_r <= ops_nxt;
         ctl_r <= ctl_nxt;
         br_r <= br_nxt;
         dv_r <= dv_nxt;
         trap_r <= trap_nxt;
         ill_r <= ill_nxt;
         bool_r <= bool_nxt;
         ext_r <= ext_nxt;
      end
   end

   assign operands_out = ops_r;
   assign ctrl_out = ctl_r;
   assign branch_out = br_r;
   assign decode_valid_out = dv_r;
   assign trap_req_out = trap_r;
   assign illegal_out = ill_r;
   assign busy_out = (state_r == rod_pkg::ROD_ST_BUSY);
   assign bool_out = bool_r;
   assign ext_data_out = ext_r;
   assign byte_order_select_out = bo_r;

   sequence s_assert_fail;
      take && instr_in[31:28] == 4'h1 && instr_in[`ROD_IMM_BIT] && !cmp_true;
   endsequence
   a_assert_trap_fires: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      s_assert_fail |=> trap_req_out) else $error("assert miss did not trap");
   a_assert_pass_quiet: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      take && cmp_true |=> !trap_req_out) else $error("trap on true condition");
   a_rel_branch_target: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      take && instr_in[31:28] == 4'h7 && !instr_in[24] |=>
      branch_out.target == $past(pc_in) + {{14{$past(instr_in[23])}}, $past(instr_in[23:8]), 2'b00})
      else $error("relative target wrong");
   a_abs_branch_target: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      take && instr_in[31:28] == 4'h7 && instr_in[24] |=> branch_out.target[1:0] == 2'b00
      && branch_out.target[17:2] == $past(instr_in[23:8])) else $error("absolute target wrong");
   a_fp_busy_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      take && instr_in[31:28] == 4'h6 |=> busy_out [*4] ##1 !busy_out)
      else $error("fp busy length wrong");
   a_single_no_busy: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      take && instr_in[31:28] == 4'h0 |=> !busy_out) else $error("single-cycle op held");
   a_illegal_class: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      take && instr_in[31:28] > 4'h8 |=> illegal_out && ctrl_out.illegal)
      else $error("illegal not flagged");
   // Equality compare checked against the raw operands, not the shared compare function
   a_bool_top_bit: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      take && instr_in[31:28] == 4'h1 && instr_in[27:25] == 3'h0 |=> bool_out[30:0] == 31'h0
      && bool_out[31] == ($past(cmp_a_in) == $past(cmp_b_in))) else $error("boolean form wrong");
   a_regs_any: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      take |=> operands_out.dst == $past(instr_in[23:16]) && operands_out.src_a == $past(instr_in[15:8]))
      else $error("register field mangled");
   a_cfg_bo_load: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      cfg_we_in |=> byte_order_select_out == $past(byte_order_select_in))
      else $error("byte order not loaded");
endmodule

// >>> sim/rod_pipe_model.sv
// Pipeline model: presents queued instruction words, operands and addresses to the decoder.
// Assumes the bench fills the queue through push; words are released only when taken.
`timescale 1ns/1ps
module rod_pipe_model (
   input wire logic mclk_in, // 50 MHz clock
   input wire logic rst_b_in, // Async reset, active low
   input wire logic accept_in, // Decoder takes the word this edge
   output logic valid_out = 1'b0, // Word present
   output logic [31:0] instr_out = 32'h00000000, // Instruction word
   output logic [31:0] pc_out = 32'h00000000, // Byte address of the word
   output logic [31:0] a_out = 32'h00000000, // Compare operand A
   output logic [31:0] b_out = 32'h00000000 // Compare operand B
);
   logic [127:0] q_r[$];
   logic [127:0] nxt;
   task automatic push(input logic [127:0] w);
      q_r.push_back(w);
   endtask
   always @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         valid_out <= 1'b0;
      end else if (!valid_out || accept_in) begin // Held unchanged while refused
         if (q_r.size() > 0) begin
            nxt = q_r.pop_front();
            valid_out <= 1'b1;
            {instr_out, pc_out, a_out, b_out} <= nxt; // One whole word per instruction
         end else begin
            valid_out <= 1'b0;
            // Idle lines flip so a stale word can never pass for a new one
            {instr_out, pc_out, a_out, b_out} <= ~{instr_out, pc_out, a_out, b_out};
         end
      end
   end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the decode front end: queued expectations, one output watcher.
// Assumes rod_pkg is compiled first and rod_regs.svh is on the include path.
`timescale 1ns/1ps
`include "rod_regs.svh"
module testbench;
   typedef struct packed {
      logic [31:0] key;
      logic [31:0] msk;
      logic [31:0] tgt;
      logic [31:0] bl;
      logic ct;
      logic cb;
      logic [31:0] im;
      logic [9:0] fl;
   } rod_exp_t;
   logic mclk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic cfg_we = 1'b0;
   logic bo = 1'b0;
   logic [31:0] ext_word = 32'h00000000;
   logic [1:0] ext_idx = 2'h0;
   logic vld, acc, dv, trap, ill, busy, bo_out;
   logic [31:0] iw, pc, ca, cb, bool_w, ext_d, r, seed, xv;
   rod_pkg::rod_operands_t ops;
   rod_pkg::rod_ctrl_t ctl;
   rod_pkg::rod_branch_t br;
   rod_exp_t exp_q[$];
   rod_exp_t we;
   int busy_q[$];
   int miscompares = 0;
   int cmp_count = 0;
   int brun = 0;
   int i, k;
   always #10 mclk_in = ~mclk_in;
   rod_pipe_model u_pipe (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .accept_in(acc), .valid_out(vld),
      .instr_out(iw), .pc_out(pc), .a_out(ca), .b_out(cb));
   rod_decoder dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .instr_valid_in(vld), .instr_in(iw), .pc_in(pc),
      .cfg_we_in(cfg_we), .byte_order_select_in(bo), .cmp_a_in(ca), .cmp_b_in(cb), .ext_word_in(ext_word),
      .ext_index_in(ext_idx), .instr_accept_out(acc), .operands_out(ops), .ctrl_out(ctl), .branch_out(br),
      .decode_valid_out(dv), .trap_req_out(trap), .illegal_out(ill), .busy_out(busy), .bool_out(bool_w),
      .ext_data_out(ext_d), .byte_order_select_out(bo_out));
   task automatic end_sim();
      $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] act, input logic [31:0] exp);
      cmp_count++;
      if (act !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask
   task automatic cmp_cnt(input int act, input int exp);
      cmp_count++;
      if (act != exp) begin
         miscompares++;
         $display("[ERR] t=%0t busy act=%h exp=%h", $time, act, exp);
      end
   endtask
   function automatic logic [7:0] rg();
      return 8'($urandom_range(191));
   endfunction
   task automatic ins(input logic [31:0] w, input logic [31:0] p, input logic [31:0] a, input logic [31:0] b);
      rod_exp_t e;
      logic [3:0] c;
      logic [2:0] s;
      logic cnd, il, mc;
      c = w[31:28];
      s = w[27:25];
      case (s)
         3'h0: cnd = a == b;
         3'h1: cnd = a != b;
         3'h2: cnd = $signed(a) < $signed(b);
         3'h3: cnd = $signed(a) <= $signed(b);
         3'h4: cnd = $signed(a) > $signed(b);
         3'h5: cnd = $signed(a) >= $signed(b);
         3'h6: cnd = a < b;
         default: cnd = a >= b;
      endcase
      il = c > 4'h8 || (c == 4'h3 && s > 3'h3) || (c == 4'h5 && s > 3'h3);
      mc = !il && (c == 4'h6 || (c == 4'h8 && s == 3'h0) || (c == 4'h4 && s > 3'h5));
      e.key = {il ? 4'hF : c, mc, il, !il && c == 4'h1 && w[24] && !cnd, w[24:0]};
      // Operand fields are compared against the word only for arithmetic and logical words
      e.msk = (c == 4'h0 || c == 4'h2) ? 32'hFFFFFFFF : 32'hFE000000;
      e.ct = c == 4'h7;
      e.tgt = w[24] ? {14'h0000, w[23:8], 2'h0} : p + {{14{w[23]}}, w[23:8], 2'h0};
      e.cb = c == 4'h1 && !w[24];
      e.bl = cnd ? `ROD_BOOL_TRUE : `ROD_BOOL_FALSE;
      e.im = c == 4'h5 ? (s == 3'h3 ? {16'hFFFF, w[23:8]} : {16'h0000, w[23:8]}) : {24'h000000, w[7:0]};
      e.fl = {s, c == 4'h4 && s == 3'h6, c == 4'h4 && s == 3'h7, c == 4'h8 && s == 3'h0, c == 4'h1 && w[24],
         c == 4'h5 && (s == 3'h1 || s == 3'h2), c == 4'h7, c == 4'h7 && w[24]};
      exp_q.push_back(e);
      if (mc) busy_q.push_back(c == 4'h6 ? `ROD_FP_CYCLES : c == 4'h8 ? `ROD_INTERRUPT_RETURN_OP_CYCLES : w[7:0] + 1);
      u_pipe.push({w, p, a, b});
   endtask
   always @(posedge mclk_in) begin
      if (dv === 1'b1) begin
         we = exp_q.size() > 0 ? exp_q.pop_front() : '0;
         cmp_word({ctl.cls, ctl.multi_cycle, ill, trap, ops.use_imm, ops.dst, ops.src_a, ops.src_b} & we.msk,
            we.key & we.msk);
         if (we.ct) cmp_word(br.target, we.tgt);
         if (we.cb) cmp_word(bool_w, we.bl);
         cmp_word(ops.imm, we.im);
         cmp_word({22'h0, ctl.sub, ctl.load_multiple_op, ctl.store_multiple_op, ctl.interrupt_return_op,
            ctl.assert_op, ctl.constant_high_op, br.is_branch, br.absolute},
            {22'h0, we.fl});
      end
      if (busy === 1'b1) brun++;
      else if (brun > 0) begin
         cmp_cnt(brun, busy_q.size() > 0 ? busy_q.pop_front() : 0);
         brun = 0;
      end
   end
   initial begin
      seed = $urandom(32'h840C);
      repeat (8) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      for (i = 0; i < 24; i++) begin
         r = $urandom;
         ins({i[0] ? 4'h2 : 4'h0, r[2:0], r[3], i < 2 ? {3{i[0] ? 8'h00 : 8'hBF}} : {rg(), rg(), rg()}}, r, r, r);
      end
      for (i = 0; i < 32; i++) begin
         r = $urandom;
         ins({4'h1, i[4:2], i[0], rg(), rg(), rg()}, r, r, i[1] ? $urandom : r);
      end
      for (i = 0; i < 5; i++) begin
         ins({4'h3, i[2:0], 1'b0, rg(), rg(), rg()}, 32'h0, 32'h0, 32'h0);
         ins({4'h5, i[2:0], 1'b0, rg(), rg(), rg()}, 32'h0, 32'h0, 32'h0);
      end
      for (i = 0; i < 8; i++) begin
         r = $urandom;
         ins({4'h7, 3'h0, i[0], i == 2 ? 16'h8000 : r[31:16], rg()}, $urandom & 32'hFFFFFFFC, 32'h0, 32'h0);
      end
      ins({4'h6, 28'h0}, 32'h0, 32'h0, 32'h0);
      ins({4'h8, 28'h0}, 32'h0, 32'h0, 32'h0);
      ins({4'h8, 3'h1, 25'h0}, 32'h0, 32'h0, 32'h0);
      ins({4'h4, 3'h6, 17'h0, 8'h00}, 32'h0, 32'h0, 32'h0);
      ins({4'h4, 3'h7, 17'h0, 8'h05}, 32'h0, 32'h0, 32'h0);
      for (i = 9; i < 16; i++) ins({i[3:0], 28'h0}, 32'h0, 32'h0, 32'h0);
      for (k = 0; k < 8; k++) begin
         while (exp_q.size() != 0) @(posedge mclk_in);
         @(posedge mclk_in);
         cfg_we <= 1'b1;
         bo <= k[0];
         ins({4'h4, k[2], 1'b0, k[1], 25'h0}, 32'h0, 32'h0, 32'h0);
         @(posedge mclk_in);
         cfg_we <= 1'b0;
         while (exp_q.size() != 0) @(posedge mclk_in);
         cmp_word({31'h0, bo_out}, {31'h0, k[0]});
         for (i = 0; i < (k[1] ? 2 : 4); i++) begin
            r = $urandom;
            ext_word <= r;
            ext_idx <= i[1:0];
            repeat (3) @(posedge mclk_in);
            xv = k[1] ? {16'h0, k[0] ? r[16*i +: 16] : r[31-16*i -: 16]} :
               {24'h0, k[0] ? r[8*i +: 8] : r[31-8*i -: 8]};
            if (k[2]) xv = k[1] ? {{16{xv[15]}}, xv[15:0]} : {{24{xv[7]}}, xv[7:0]};
            cmp_word(ext_d, xv);
         end
      end
      repeat (10) @(posedge mclk_in);
      end_sim();
   end
   initial begin
      repeat (5000) @(posedge mclk_in);
      miscompares++;
      end_sim();
   end
endmodule
